// ---- pfs_pkg.sv ----
// constants and register map of the pin function select bank
package pfs_pkg;

    // ----------------------------------------------------------------
    // register offsets, byte addresses from the system register base
    // ----------------------------------------------------------------
    localparam logic [11:0] PFS_PORT_A_LOW_OFS  = 12'h030;
    localparam logic [11:0] PFS_PORT_A_HIGH_OFS = 12'h034;
    localparam logic [11:0] PFS_PORT_B_LOW_OFS  = 12'h038;
    localparam logic [11:0] PFS_PORT_B_HIGH_OFS = 12'h03C;
    localparam logic [11:0] PFS_PORT_C_LOW_OFS  = 12'h040;
    localparam logic [11:0] PFS_PORT_C_HIGH_OFS = 12'h044;
    localparam logic [11:0] PFS_PORT_D_LOW_OFS  = 12'h048;
    localparam logic [11:0] PFS_PORT_D_HIGH_OFS = 12'h04C;
    localparam logic [11:0] PFS_PORT_E_LOW_OFS  = 12'h050;
    localparam logic [11:0] PFS_PORT_E_HIGH_OFS = 12'h054;
    localparam logic [11:0] PFS_PORT_F_LOW_OFS  = 12'h058;
    localparam logic [11:0] PFS_PORT_F_HIGH_OFS = 12'h05C;

    // ----------------------------------------------------------------
    // layout
    // ----------------------------------------------------------------
    localparam int PFS_NUM_REGS   = 12;
    localparam int PFS_NUM_PORTS  = 6;
    localparam int PFS_FIELD_W    = 4;
    localparam int PFS_PINS_PER_REG = 8;

    // ----------------------------------------------------------------
    // reset values and implemented-bit masks, index 0 = port a low
    // ----------------------------------------------------------------
    localparam logic [31:0] PFS_ZERO_RST       = 32'h0000_0000;
    localparam logic [31:0] PFS_PORT_F_LOW_RST = 32'h0000_00EE;
    localparam logic [31:0] PFS_FULL_MASK      = 32'hFFFF_FFFF;
    localparam logic [31:0] PFS_PORT_C_HIGH_MASK = 32'h00FF_FFFF;
    localparam logic [31:0] PFS_PORT_D_HIGH_MASK = 32'h0FFF_FFFF;
    localparam logic [31:0] PFS_PORT_F_HIGH_MASK = 32'h0000_FFFF;

    localparam logic [31:0] PFS_RST_VAL [PFS_NUM_REGS] = '{
        PFS_ZERO_RST, PFS_ZERO_RST, PFS_ZERO_RST, PFS_ZERO_RST,
        PFS_ZERO_RST, PFS_ZERO_RST, PFS_ZERO_RST, PFS_ZERO_RST,
        PFS_ZERO_RST, PFS_ZERO_RST, PFS_PORT_F_LOW_RST, PFS_ZERO_RST};

    localparam logic [31:0] PFS_RW_MASK [PFS_NUM_REGS] = '{
        PFS_FULL_MASK, PFS_FULL_MASK, PFS_FULL_MASK, PFS_FULL_MASK,
        PFS_FULL_MASK, PFS_PORT_C_HIGH_MASK, PFS_FULL_MASK, PFS_PORT_D_HIGH_MASK,
        PFS_FULL_MASK, PFS_FULL_MASK, PFS_FULL_MASK, PFS_PORT_F_HIGH_MASK};

    // ----------------------------------------------------------------
    // bus responses
    // ----------------------------------------------------------------
    localparam logic [1:0] PFS_RESP_OKAY   = 2'h0;
    localparam logic [1:0] PFS_RESP_SLVERR = 2'h2;

endpackage : pfs_pkg

// ---- pfs_bank.sv ----
// pin function select register bank for ports a to f, axi4-lite slave
// Notes on behaviour
// [RQ1] lower register holds pins 0..7, pin n at bits 4n+3..4n
// [RQ2] upper register holds pins 8..15, pin n at bits 4(n-8)+3..4(n-8)
// [RQ3] port a at 0x30/0x34, each next port eight bytes further, low first
// [RQ4] reset clears all registers of ports a..e and port f upper
// [RQ5] reset loads port f lower register with 0x0000_00EE
// [RQ6] port c upper keeps pins 8..13 only, bits 31..24 reserved
// [RQ7] port d upper keeps pins 8..14 only, bits 31..28 reserved
// [RQ8] every register is 32-bit read/write, reads return last written value; the code keeps only bits 15..0 of port f upper, bits 31..16 read zero
// [RQ9] reserved bits read as zero and ignore writes
// [RQ10] each field drives its pin mux, zero selects plain gpio
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps

module pfs_bank
    import pfs_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // clock, reset, enable
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi4-lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // pin mux selections, four bits per pin, pin 0 lowest
    output logic [63:0]            port_a_function,
    output logic [63:0]            port_b_function,
    output logic [63:0]            port_c_function,
    output logic [63:0]            port_d_function,
    output logic [63:0]            port_e_function,
    output logic [63:0]            port_f_function
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (ADDR_W < 7 || ADDR_W > 12) begin : g_bad_addr_w
        $error("pfs_bank: ADDR_W must lie in 7..12");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [31:0]       sel_q [PFS_NUM_REGS];
    logic [ADDR_W-1:0] waddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              aw_hold_q;
    logic              w_hold_q;
    logic              awready_q;
    logic              wready_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              arready_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;

    logic              aw_take;
    logic              w_take;
    logic              ar_take;
    logic              do_write;
    logic              w_hit;
    logic [3:0]        w_idx;
    logic              r_hit;
    logic [3:0]        r_idx;
    logic [31:0]       byte_mask;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        logic [11:0] wide;
        wide = 12'(a);
        addr_hit = (wide >= PFS_PORT_A_LOW_OFS) && (wide <= PFS_PORT_F_HIGH_OFS)
                   && (wide[1:0] == 2'h0);
    endfunction : addr_hit

    function automatic logic [3:0] addr_index(input logic [ADDR_W-1:0] a);
        logic [11:0] diff;
        diff = 12'(a) - PFS_PORT_A_LOW_OFS;
        addr_index = diff[5:2];
    endfunction : addr_index

    assign aw_take  = ce && s_axi_awvalid && awready_q;
    assign w_take   = ce && s_axi_wvalid && wready_q;
    assign ar_take  = ce && s_axi_arvalid && arready_q;
    assign do_write = ce && aw_hold_q && w_hold_q && !bvalid_q;
    assign w_hit    = addr_hit(waddr_q);                              // RQ3
    assign w_idx    = addr_index(waddr_q);                            // RQ3
    assign r_hit    = addr_hit(s_axi_araddr);                         // RQ3
    assign r_idx    = addr_index(s_axi_araddr);                       // RQ3
    assign byte_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    // ----------------------------------------------------------------
    // selection registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int i = 0; i < PFS_NUM_REGS; i++) begin
                sel_q[i] <= PFS_RST_VAL[i];                           // RQ4 RQ5
            end
        end else if (do_write && w_hit) begin
            // reserved bits are masked off and stay zero
            sel_q[w_idx] <= ((sel_q[w_idx] & ~byte_mask) | (wdata_q & byte_mask))
                            & PFS_RW_MASK[w_idx];                     // RQ8 RQ9 RQ6 RQ7
        end
    end

    // ----------------------------------------------------------------
    // write channel: address and data taken in either order
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            aw_hold_q <= 1'b0;
            awready_q <= 1'b1;
            waddr_q   <= '0;
        end else if (aw_take) begin
            aw_hold_q <= 1'b1;
            awready_q <= 1'b0;
            waddr_q   <= s_axi_awaddr;
        end else if (do_write) begin
            aw_hold_q <= 1'b0;
        end else if (ce && bvalid_q && s_axi_bready) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            w_hold_q <= 1'b0;
            wready_q <= 1'b1;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end else if (w_take) begin
            w_hold_q <= 1'b1;
            wready_q <= 1'b0;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end else if (do_write) begin
            w_hold_q <= 1'b0;
        end else if (ce && bvalid_q && s_axi_bready) begin
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q  <= PFS_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= w_hit ? PFS_RESP_OKAY : PFS_RESP_SLVERR;
        end else if (ce && bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= PFS_RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= r_hit ? sel_q[r_idx] : 32'h0000_0000;        // RQ8
            rresp_q   <= r_hit ? PFS_RESP_OKAY : PFS_RESP_SLVERR;
        end else if (ce && rvalid_q && s_axi_rready) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // field of pin n of a port sits at bits 4n+3..4n of its pair
    assign port_a_function = {sel_q[1],  sel_q[0]};                   // RQ1 RQ2 RQ10
    assign port_b_function = {sel_q[3],  sel_q[2]};                   // RQ1 RQ2 RQ10
    assign port_c_function = {sel_q[5],  sel_q[4]};                   // RQ1 RQ2 RQ10
    assign port_d_function = {sel_q[7],  sel_q[6]};                   // RQ1 RQ2 RQ10
    assign port_e_function = {sel_q[9],  sel_q[8]};                   // RQ1 RQ2 RQ10
    assign port_f_function = {sel_q[11], sel_q[10]};                  // RQ1 RQ2 RQ10

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_reset_clears: assert property (@(posedge mclk)  // RQ4
        !rst_n |=> (port_a_function == 64'h0) && (port_b_function == 64'h0)
                   && (port_c_function == 64'h0) && (port_d_function == 64'h0)
                   && (port_e_function == 64'h0) && (port_f_function[63:32] == 32'h0))
        else $error("selection register not cleared by reset");

    a_reset_port_f: assert property (@(posedge mclk)  // RQ5
        !rst_n |=> port_f_function[31:0] == PFS_PORT_F_LOW_RST)
        else $error("port f lower register reset value wrong");

    a_port_c_reserved: assert property (@(posedge mclk) disable iff (!rst_n)  // RQ6
        port_c_function[63:56] == 8'h00)
        else $error("port c reserved bits not zero");

    a_port_d_reserved: assert property (@(posedge mclk) disable iff (!rst_n)  // RQ7
        port_d_function[63:60] == 4'h0)
        else $error("port d reserved bits not zero");

    a_port_f_reserved: assert property (@(posedge mclk) disable iff (!rst_n)  // RQ9
        port_f_function[63:48] == 16'h0000)
        else $error("port f upper reserved bits not zero");

    a_write_lands_a: assert property (@(posedge mclk) disable iff (!rst_n)  // RQ3
        (do_write && 12'(waddr_q) == PFS_PORT_A_HIGH_OFS && wstrb_q == 4'hF)
        |=> port_a_function[63:32] == $past(wdata_q))
        else $error("write to port a upper did not land on pins 8..15");

    a_write_lands_e: assert property (@(posedge mclk) disable iff (!rst_n)  // RQ1
        (do_write && 12'(waddr_q) == PFS_PORT_E_LOW_OFS && wstrb_q == 4'hF)
        |=> port_e_function[3:0] == $past(wdata_q[3:0])
            && port_e_function[31:28] == $past(wdata_q[31:28]))
        else $error("write to port e lower misplaced pin fields");

    a_read_returns: assert property (@(posedge mclk) disable iff (!rst_n)  // RQ8
        (ar_take && 12'(s_axi_araddr) == PFS_PORT_F_LOW_OFS)
        |=> s_axi_rvalid && s_axi_rresp == PFS_RESP_OKAY
            && s_axi_rdata == $past(port_f_function[31:0]))
        else $error("read of port f lower returned wrong data");

    a_unmapped_read: assert property (@(posedge mclk) disable iff (!rst_n)
        (ar_take && !r_hit) |=> s_axi_rresp == PFS_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not answered with error and zero");

    a_write_answer: assert property (@(posedge mclk) disable iff (!rst_n)  // RQ8
        (aw_take && w_take) ##1 ce |=> s_axi_bvalid)
        else $error("write response did not follow an enabled cycle after taking");

    a_read_holds: assert property (@(posedge mclk) disable iff (!rst_n)
        (s_axi_rvalid && !(ce && s_axi_rready)) |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");

    a_freeze_all: assert property (@(posedge mclk) disable iff (!rst_n)
        !ce |=> $stable(port_b_function) && $stable(s_axi_bvalid)
                && $stable(s_axi_arready))
        else $error("state changed while clock enable low");

    a_write_lands_c: assert property (@(posedge mclk) disable iff (!rst_n)  // RQ6
        (do_write && 12'(waddr_q) == PFS_PORT_C_HIGH_OFS && wstrb_q == 4'hF)
        |=> port_c_function[55:32] == $past(wdata_q[23:0]))
        else $error("write to port c upper misplaced pins 8..13");

    a_write_lands_d: assert property (@(posedge mclk) disable iff (!rst_n)  // RQ7
        (do_write && 12'(waddr_q) == PFS_PORT_D_HIGH_OFS && wstrb_q == 4'hF)
        |=> port_d_function[59:32] == $past(wdata_q[27:0]))
        else $error("write to port d upper misplaced pins 8..14");

    a_strobe_keeps: assert property (@(posedge mclk) disable iff (!rst_n)  // RQ8
        (do_write && 12'(waddr_q) == PFS_PORT_B_LOW_OFS && wstrb_q == 4'h5)
        |=> port_b_function[15:8] == $past(port_b_function[15:8])
            && port_b_function[31:24] == $past(port_b_function[31:24]))
        else $error("write changed a byte lane whose strobe was low");

    a_unmapped_write: assert property (@(posedge mclk) disable iff (!rst_n)  // RQ3
        (do_write && !w_hit) |=> s_axi_bvalid && s_axi_bresp == PFS_RESP_SLVERR
            && $stable(port_a_function) && $stable(port_f_function))
        else $error("unmapped write not refused");

    a_resp_holds: assert property (@(posedge mclk) disable iff (!rst_n)
        (s_axi_bvalid && !(ce && s_axi_bready)) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");

    a_one_write: assert property (@(posedge mclk) disable iff (!rst_n)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write accepted while response pending");

endmodule : pfs_bank

// ---- pfs_testbench.sv ----
// self-checking testbench of the pin function select bank
`timescale 1ns/1ps

module testbench;
    import pfs_pkg::*;

    // ----------------------------------------------------------------
    // signals and reference model
    // ----------------------------------------------------------------
    logic        mclk, rst_n, ce, ce_rand;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [63:0] pins [6];
    logic [31:0] mdl [12];
    logic [11:0] ra;
    int          errors, comparisons;

    pfs_bank dut_u (
        .mclk(mclk), .rst_n(rst_n), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .port_a_function(pins[0]), .port_b_function(pins[1]),
        .port_c_function(pins[2]), .port_d_function(pins[3]),
        .port_e_function(pins[4]), .port_f_function(pins[5]));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // random clock enable stalls the bus in the later tests
    always @(posedge mclk) ce <= ce_rand ? ($urandom_range(3) != 0) : 1'b1;

    // ----------------------------------------------------------------
    // model helpers and compares
    // ----------------------------------------------------------------
    function automatic int ridx(logic [11:0] a);
        if (a >= 12'h030 && a <= 12'h05C && a[1:0] == 2'h0) return int'(a - 12'h030) / 4;
        return -1;
    endfunction : ridx

    function automatic logic [31:0] rmask(int i);
        if (i == 5) return 32'h00FF_FFFF;
        if (i == 7) return 32'h0FFF_FFFF;
        if (i == 11) return 32'h0000_FFFF;
        return 32'hFFFF_FFFF;
    endfunction : rmask

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD data t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_data

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD resp t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_resp

    task automatic chk_pins(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD pins t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_pins

    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    task automatic bus_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int  i;
        bit  aw, w;
        i = ridx(a);
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw || w) begin
            @(posedge mclk);
            if (aw && awready === 1'b1 && ce === 1'b1) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1 && ce === 1'b1) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge mclk); while (!(bvalid === 1'b1 && ce === 1'b1));
        chk_resp(bresp, (i < 0) ? PFS_RESP_SLVERR : PFS_RESP_OKAY);
        if (i >= 0) begin
            for (int b = 0; b < 4; b++) begin
                if (s[b]) mdl[i][8*b+:8] = d[8*b+:8];
            end
            mdl[i] = mdl[i] & rmask(i);
            chk_pins(pins[i/2], {mdl[i|1], mdl[i&~1]});
        end
    endtask : bus_write

    task automatic bus_read(input logic [11:0] a);
        int i;
        i = ridx(a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge mclk); while (!(arready === 1'b1 && ce === 1'b1));
        arvalid <= 1'b0;
        do @(posedge mclk); while (!(rvalid === 1'b1 && ce === 1'b1));
        chk_resp(rresp, (i < 0) ? PFS_RESP_SLVERR : PFS_RESP_OKAY);
        chk_data(rdata, (i < 0) ? 32'h0000_0000 : mdl[i]);
    endtask : bus_read

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (mdl[k]) mdl[k] = (k == 10) ? 32'h0000_00EE : 32'h0000_0000;
        @(posedge mclk);
        for (int p = 0; p < 6; p++) chk_pins(pins[p], {mdl[2*p+1], mdl[2*p]});
        for (int k = 0; k < 12; k++) bus_read(12'(12'h030 + 4 * k));
    endtask : do_reset

    task automatic tally_and_finish;
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (60000) @(posedge mclk);
        errors++;
        tally_and_finish();
    end

    initial begin
        {errors, comparisons} = '0;
        ce_rand = 1'b0;
        {awvalid, wvalid, arvalid} <= 3'b000;
        {awaddr, araddr, wdata, wstrb, bready, rready} <= {24'h0, 32'h0, 4'h0, 2'b11};
        void'($urandom(32'hA765));
        do_reset();
        $display("test reset_values done");
        for (int k = 0; k < 12; k++) begin
            bus_write(12'(12'h030 + 4 * k), 32'hFFFF_FFFF, 4'hF);
            bus_read(12'(12'h030 + 4 * k));
            bus_write(12'(12'h030 + 4 * k), 32'h8765_4321 + k, 4'hF);
            bus_read(12'(12'h030 + 4 * k));
            bus_write(12'(12'h030 + 4 * k), 32'h0000_0000, 4'h5);
        end
        $display("test field_layout done");
        for (int b = 0; b < 12; b++) begin
            bus_write(12'h02C ^ (12'h001 << b), $urandom(), 4'hF);
            bus_read(12'h02C ^ (12'h001 << b));
        end
        $display("test unmapped done");
        ce_rand = 1'b1;
        repeat (300) begin
            ra = 12'(12'h028 + 4 * $urandom_range(17) + ($urandom_range(7) == 0));
            if ($urandom_range(1) == 1) bus_write(ra, $urandom(), 4'($urandom()));
            else bus_read(ra);
        end
        $display("test random_traffic done");
        do_reset();
        ce_rand = 1'b0;
        $display("test second_reset done");
        tally_and_finish();
    end

endmodule : testbench
